// ### design/mcsub_ctrl.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Eight modulation kinds plus off; any kind but off enables modulation.
// - Switching modulation on starts modulated output automatically.
// - Inconsistent settings block output and raise conflict; start when valid.
// - Pause outputs plain carrier; resume restarts modulation.
// - Internal source offers eight shapes including table and shaped wave.
// - Noise shape ignores the internal rate setting.
// - Binary keying kinds force a half-duty square internal shape.
// - User table shape reads a 4096-sample converted table.
// - Phase setting offsets modulating phase; shared phase reference.
// - Source selects internal, external, external one or external two.
// - External analogue input full scale gives the set modulation width.
// - External input used for addition disables external modulation, except for the FSK and PSK keying kinds.
// - External keying comes on trigger input with selectable polarity.
// - Aux selector options depend on source; waveform barred for keying.
// - Reference sync rises at the main waveform reference phase.
// - Modulation sync is half-duty square rising at modulation zero phase.
// - Modulation sync with noise shape holds aux output low.
// - Modulation waveform on aux is scaled by amplitude, shifted by the phase setting value.
// - Sub waveform has own shape, amplitude and phase; no offset is added.
// - Aux off drives a zero-volt code.
// - FM swings frequency by peak deviation around carrier.
// - FM conflicts with noise, pulse or DC carrier or frequency sweep.
// - Internal source refused while sweep mode is active.
// - Zero modulation width leaves main output unmodulated, except FSK, which still hops to the alternate frequency.
// - External FSK positive polarity: low carrier, high alternate; negative reverses.
module mcsub_ctrl (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire mcsub_pkg::mcs_bus_t bus,
  input wire logic ext_trigger,
  input wire logic signed [15:0] ext_analog,
  input wire logic main_phase_msb,
  input wire logic phase_ref_zero,
  output logic [31:0] rdata_ff,
  output logic [31:0] out_freq_ff,
  output logic signed [15:0] out_mod_ff,
  output logic mod_active_ff,
  output logic conflict_ff,
  output logic signed [15:0] aux_code_ff
);
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_PAUSED, ST_BLOCKED} mcs_state_t;

  logic [31:0] ctrl_ff, rate_ff, carrier_ff, alt_ff, aux_ff, aux_rate_ff;
  logic [15:0] phase_ff, width_ff;
  logic [7:0] shape_ff;
  logic [11:0] tbl_ptr_ff;
  logic signed [15:0] tbl_mem [0:mcsub_pkg::TBL_DEPTH-1];
  logic [31:0] mod_acc_ff, aux_acc_ff;
  logic [15:0] lfsr_ff;
  logic trig1_ff, trig2_ff, trig3_ff, key_level_ff;
  mcs_state_t st_ff, nxt_st;

  // Scaled product, saturated to 16 bits
  function automatic logic signed [15:0] scale(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
    logic signed [31:0] p;
    logic signed [16:0] q;
    p = a * b;
    q = p[31:15];
    if (q > 17'sh07fff) scale = 16'sh7fff;
    else if (q < -17'sh07fff) scale = -16'sh7fff;
    else scale = q[15:0];
  endfunction : scale

  // Saturating sum
  function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
                                                 input logic signed [15:0] b);
    logic signed [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s > 17'sh07fff) sat_add = 16'sh7fff;
    else if (s < -17'sh07fff) sat_add = -16'sh7fff;
    else sat_add = s[15:0];
  endfunction : sat_add

  // Waveform sample from a 16-bit phase
  function automatic logic signed [15:0] shape_val(input logic [2:0] sh,
                                                   input logic [15:0] ph,
                                                   input logic [15:0] noise,
                                                   input logic signed [15:0] tbl);
    logic [29:0] par;
    logic [15:0] tri_v;
    logic signed [16:0] tr2;
    par = 30'(ph[14:0]) * 30'(15'h7fff - ph[14:0]);
    tri_v = ph[15] ? ~{ph[14:0], 1'b0} : {ph[14:0], 1'b0};
    tri_v = tri_v ^ 16'h8000;
    tr2 = {$signed(tri_v), 1'b0};
    case (sh)
      mcsub_pkg::SH_SINE: shape_val = ph[15] ? -$signed({1'b0, par[27:13]})
                                             : $signed({1'b0, par[27:13]});
      mcsub_pkg::SH_SQUARE: shape_val = ph[15] ? mcsub_pkg::AUX_LO : mcsub_pkg::AUX_HI;
      mcsub_pkg::SH_TRIANGLE: shape_val = $signed(tri_v);
      mcsub_pkg::SH_RISE: shape_val = $signed(ph ^ 16'h8000);
      mcsub_pkg::SH_FALL: shape_val = $signed(~(ph ^ 16'h8000));
      mcsub_pkg::SH_NOISE: shape_val = $signed(noise);
      mcsub_pkg::SH_TABLE: shape_val = tbl;
      mcsub_pkg::SH_SHAPED: shape_val = (tr2 > 17'sh07fff) ? 16'sh7fff :
                                        (tr2 < -17'sh07fff) ? -16'sh7fff : tr2[15:0];
      default: shape_val = 16'sh0000;
    endcase
  endfunction : shape_val

  // Field views of the control, shape and aux registers
  logic [3:0] kind;
  logic [1:0] src, aux_sel;
  logic [1:0] car_class;
  logic pol, add_use, sweep_on, fsweep_on, enabled, keying, ext_src, conflict_now;
  logic [2:0] int_shape, aux_wave;
  assign kind = ctrl_ff[mcsub_pkg::CTRL_KIND_LSB +: 4];
  assign src = ctrl_ff[mcsub_pkg::CTRL_SRC_LSB +: 2];
  assign pol = ctrl_ff[mcsub_pkg::CTRL_POL_BIT];
  assign add_use = ctrl_ff[mcsub_pkg::CTRL_ADD_BIT];
  assign sweep_on = ctrl_ff[mcsub_pkg::CTRL_SWEEP_BIT];
  assign fsweep_on = ctrl_ff[mcsub_pkg::CTRL_FSWEEP_BIT];
  assign car_class = ctrl_ff[mcsub_pkg::CTRL_CARR_LSB +: 2];
  assign aux_sel = aux_ff[mcsub_pkg::AUX_SEL_LSB +: 2];
  assign enabled = (kind != mcsub_pkg::MCS_OFF);
  assign keying = (kind == mcsub_pkg::MCS_FSK) || (kind == mcsub_pkg::MCS_PSK);
  assign ext_src = (src != mcsub_pkg::SRC_INT);
  // Keying kinds always use a half-duty square
  assign int_shape = keying ? 3'(mcsub_pkg::SH_SQUARE) : shape_ff[2:0];
  assign aux_wave = shape_ff[mcsub_pkg::SHAPE_AUX_LSB +: 3];

  // Settings that cannot modulate together
  always_comb
  begin
    conflict_now = 1'b0;
    if (kind > 4'(mcsub_pkg::MCS_PWM))
      conflict_now = 1'b1;
    if (kind == mcsub_pkg::MCS_FM && (car_class != 2'(mcsub_pkg::CAR_NORMAL) || fsweep_on))
      conflict_now = 1'b1;
    if (enabled && !ext_src && sweep_on)
      conflict_now = 1'b1;
    if (enabled && !keying && ext_src && add_use)
      conflict_now = 1'b1;
  end

  // Register writes and the table loader
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_ff <= mcsub_pkg::CTRL_RST;
      shape_ff <= 8'h00;
      rate_ff <= mcsub_pkg::RATE_RST;
      phase_ff <= 16'h0000;
      width_ff <= mcsub_pkg::WIDTH_RST;
      carrier_ff <= 32'h0000_0000;
      alt_ff <= 32'h0000_0000;
      aux_ff <= 32'h0000_0003;
      aux_rate_ff <= mcsub_pkg::RATE_RST;
      tbl_ptr_ff <= 12'h000;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        mcsub_pkg::OFS_CTRL: ctrl_ff <= {20'h00000, bus.wdata[11:0]};
        mcsub_pkg::OFS_SHAPE: shape_ff <= {1'b0, bus.wdata[6:4], 1'b0, bus.wdata[2:0]};
        mcsub_pkg::OFS_RATE: rate_ff <= bus.wdata;
        mcsub_pkg::OFS_PHASE: phase_ff <= bus.wdata[15:0];
        mcsub_pkg::OFS_WIDTH: width_ff <= bus.wdata[15:0];
        mcsub_pkg::OFS_CARRIER: carrier_ff <= bus.wdata;
        mcsub_pkg::OFS_ALT: alt_ff <= bus.wdata;
        mcsub_pkg::OFS_AUX: aux_ff <= bus.wdata;
        mcsub_pkg::OFS_AUX_RATE: aux_rate_ff <= bus.wdata;
        mcsub_pkg::OFS_TBL_PTR: tbl_ptr_ff <= bus.wdata[11:0];
        mcsub_pkg::OFS_TBL_DATA: tbl_ptr_ff <= tbl_ptr_ff + 12'h001;
        default: ;
      endcase
    end
  end

  // Converted user table, 4096 samples
  always_ff @(posedge sys_clk)
  begin
    if (bus.wr && bus.addr == mcsub_pkg::OFS_TBL_DATA)
      tbl_mem[tbl_ptr_ff] <= bus.wdata[15:0];
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_ff <= 32'h0000_0000;
    else if (bus.rd)
    begin
      case (bus.addr)
        mcsub_pkg::OFS_CTRL: rdata_ff <= ctrl_ff;
        mcsub_pkg::OFS_SHAPE: rdata_ff <= {24'h000000, shape_ff};
        mcsub_pkg::OFS_RATE: rdata_ff <= rate_ff;
        mcsub_pkg::OFS_PHASE: rdata_ff <= {16'h0000, phase_ff};
        mcsub_pkg::OFS_WIDTH: rdata_ff <= {16'h0000, width_ff};
        mcsub_pkg::OFS_CARRIER: rdata_ff <= carrier_ff;
        mcsub_pkg::OFS_ALT: rdata_ff <= alt_ff;
        mcsub_pkg::OFS_AUX: rdata_ff <= aux_ff;
        mcsub_pkg::OFS_AUX_RATE: rdata_ff <= aux_rate_ff;
        mcsub_pkg::OFS_STATUS: rdata_ff <= {27'h0000000, key_level_ff, enabled,
                                            st_ff == ST_PAUSED, conflict_ff, mod_active_ff};
        mcsub_pkg::OFS_TBL_PTR: rdata_ff <= {20'h00000, tbl_ptr_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Trigger pin sync; key level changes when stages two and three agree
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      trig1_ff <= 1'b0;
      trig2_ff <= 1'b0;
      trig3_ff <= 1'b0;
      key_level_ff <= 1'b0;
    end
    else
    begin
      trig1_ff <= ext_trigger;
      trig2_ff <= trig1_ff;
      trig3_ff <= trig2_ff;
      if (trig2_ff == trig3_ff)
        key_level_ff <= trig3_ff;
    end
  end

  // Modulation and sub waveform accumulators, common phase reference
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mod_acc_ff <= 32'h0000_0000;
      aux_acc_ff <= 32'h0000_0000;
    end
    else if (phase_ref_zero)
    begin
      mod_acc_ff <= 32'h0000_0000;
      aux_acc_ff <= 32'h0000_0000;
    end
    else
    begin
      mod_acc_ff <= mod_acc_ff + rate_ff;
      aux_acc_ff <= aux_acc_ff + aux_rate_ff;
    end
  end

  // Noise runs every clock, rate setting not used
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      lfsr_ff <= mcsub_pkg::LFSR_SEED;
    else
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
  end

  // Sample values of both internal sources
  logic [15:0] mod_ph, aux_ph;
  logic signed [15:0] int_val, aux_val, mod_val, key_val;
  logic key_now;
  assign mod_ph = mod_acc_ff[31:16] + phase_ff;
  assign aux_ph = aux_acc_ff[31:16] + aux_ff[31:16];
  assign int_val = shape_val(int_shape, mod_ph, lfsr_ff, tbl_mem[mod_ph[15:4]]);
  assign aux_val = shape_val(aux_wave, aux_ph, lfsr_ff, tbl_mem[aux_ph[15:4]]);
  assign key_now = key_level_ff ^ pol;
  assign key_val = key_now ? mcsub_pkg::AUX_HI : mcsub_pkg::AUX_LO;
  // External analogue, full scale maps to the set width
  assign mod_val = ext_src ? (keying ? key_val : ext_analog) : int_val;

  // Run state: auto start, conflict block, pause and resume
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_OFF: if (enabled) nxt_st = conflict_now ? ST_BLOCKED : ST_RUN;
      ST_RUN:
        if (!enabled) nxt_st = ST_OFF;
        else if (conflict_now) nxt_st = ST_BLOCKED;
        else if (bus.wr && bus.addr == mcsub_pkg::OFS_CMD
                 && bus.wdata[mcsub_pkg::CMD_PAUSE_BIT])
          nxt_st = ST_PAUSED;
      ST_PAUSED:
        if (!enabled) nxt_st = ST_OFF;
        else if (bus.wr && bus.addr == mcsub_pkg::OFS_CMD
                 && bus.wdata[mcsub_pkg::CMD_RESUME_BIT])
          nxt_st = conflict_now ? ST_BLOCKED : ST_RUN;
      ST_BLOCKED:
        if (!enabled) nxt_st = ST_OFF;
        else if (!conflict_now) nxt_st = ST_RUN;
      default: nxt_st = ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= ST_OFF;
      mod_active_ff <= 1'b0;
      conflict_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      mod_active_ff <= (nxt_st == ST_RUN);
      conflict_ff <= enabled && conflict_now;
    end
  end

  // Main modulation outputs, whole samples per edge
  logic signed [15:0] dev;
  logic signed [31:0] dev_ext;
  assign dev = scale(mod_val, $signed(width_ff));
  assign dev_ext = 32'(dev);
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_freq_ff <= 32'h0000_0000;
      out_mod_ff <= 16'sh0000;
    end
    else if (nxt_st != ST_RUN)
    begin
      out_freq_ff <= carrier_ff;
      out_mod_ff <= 16'sh0000;
    end
    else if (kind == mcsub_pkg::MCS_FSK)
    begin
      out_freq_ff <= key_now || (!ext_src && !mod_ph[15]) ? alt_ff : carrier_ff;
      out_mod_ff <= 16'sh0000;
    end
    else if (kind == mcsub_pkg::MCS_FM)
    begin
      out_freq_ff <= carrier_ff + dev_ext;
      out_mod_ff <= dev;
    end
    else
    begin
      out_freq_ff <= carrier_ff;
      out_mod_ff <= keying ? (mod_val[15] ? 16'sh0000 : $signed(width_ff)) : dev;
    end
  end

  // Sync/sub output multiplexer
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      aux_code_ff <= mcsub_pkg::AUX_ZERO;
    else
    begin
      case (aux_sel)
        mcsub_pkg::AUX_SYNC:
          aux_code_ff <= main_phase_msb ? mcsub_pkg::AUX_LO : mcsub_pkg::AUX_HI;
        mcsub_pkg::AUX_MOD_SYNC:
          if (!enabled || ext_src) aux_code_ff <= mcsub_pkg::AUX_ZERO;
          else if (int_shape == 3'(mcsub_pkg::SH_NOISE)) aux_code_ff <= mcsub_pkg::AUX_LO;
          else aux_code_ff <= mod_ph[15] ? mcsub_pkg::AUX_LO : mcsub_pkg::AUX_HI;
        mcsub_pkg::AUX_WAVE:
          if (enabled && !ext_src)
            aux_code_ff <= keying ? mcsub_pkg::AUX_ZERO :
              sat_add(scale(int_val, $signed(aux_ff[15:0])), $signed(phase_ff));
          else
            aux_code_ff <= sat_add(scale(aux_val, $signed(aux_ff[15:0])), 16'sh0000);
        default: aux_code_ff <= mcsub_pkg::AUX_ZERO;
      endcase
    end
  end

  // Checks
  property p_auto_start;
    @(posedge sys_clk) disable iff (sys_rst)
      (st_ff == ST_OFF && enabled && !conflict_now) |=> mod_active_ff;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("no auto start");

  property p_conflict;
    @(posedge sys_clk) disable iff (sys_rst)
      (enabled && conflict_now) |=> (conflict_ff && !mod_active_ff);
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not blocking");

  property p_pause;
    @(posedge sys_clk) disable iff (sys_rst)
      (st_ff == ST_RUN && enabled && !conflict_now && bus.wr && bus.addr == mcsub_pkg::OFS_CMD
       && bus.wdata[0]) |=> (!mod_active_ff && out_mod_ff == 16'sh0000
       && out_freq_ff == $past(carrier_ff));
  endproperty
  a_pause: assert property (p_pause) else $error("pause left modulation on");

  property p_resume;
    @(posedge sys_clk) disable iff (sys_rst)
      (st_ff == ST_PAUSED && enabled && !conflict_now && bus.wr
       && bus.addr == mcsub_pkg::OFS_CMD && bus.wdata[1]) |=> mod_active_ff;
  endproperty
  a_resume: assert property (p_resume) else $error("resume failed");

  property p_fsk_key;
    @(posedge sys_clk) disable iff (sys_rst)
      (nxt_st == ST_RUN && kind == mcsub_pkg::MCS_FSK && ext_src)
      |=> out_freq_ff == (($past(key_level_ff) ^ $past(pol)) ? $past(alt_ff) : $past(carrier_ff));
  endproperty
  a_fsk_key: assert property (p_fsk_key) else $error("fsk key mapping wrong");

  property p_zero_width;
    @(posedge sys_clk) disable iff (sys_rst)
      (kind == mcsub_pkg::MCS_FM && width_ff == 16'h0000) |=> out_freq_ff == $past(carrier_ff);
  endproperty
  a_zero_width: assert property (p_zero_width) else $error("zero width modulated");

  property p_add_block;
    @(posedge sys_clk) disable iff (sys_rst)
      (enabled && !keying && ext_src && add_use) |=> !mod_active_ff;
  endproperty
  a_add_block: assert property (p_add_block) else $error("ext modulation with addition");

  property p_sweep_int;
    @(posedge sys_clk) disable iff (sys_rst)
      (enabled && !ext_src && sweep_on) |=> conflict_ff;
  endproperty
  a_sweep_int: assert property (p_sweep_int) else $error("internal source in sweep");

  property p_fm_carrier;
    @(posedge sys_clk) disable iff (sys_rst)
      (kind == mcsub_pkg::MCS_FM && car_class != 2'(mcsub_pkg::CAR_NORMAL)) |=> conflict_ff;
  endproperty
  a_fm_carrier: assert property (p_fm_carrier) else $error("fm carrier conflict missed");

  property p_aux_off;
    @(posedge sys_clk) disable iff (sys_rst)
      (aux_sel == 2'(mcsub_pkg::AUX_OFFSEL)) |=> aux_code_ff == mcsub_pkg::AUX_ZERO;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux off not zero");

  property p_mod_sync_noise;
    @(posedge sys_clk) disable iff (sys_rst)
      (aux_sel == 2'(mcsub_pkg::AUX_MOD_SYNC) && enabled && !ext_src && !keying
       && shape_ff[2:0] == 3'(mcsub_pkg::SH_NOISE)) |=> aux_code_ff == mcsub_pkg::AUX_LO;
  endproperty
  a_mod_sync_noise: assert property (p_mod_sync_noise) else $error("mod sync not low");

  property p_cov_pause_resume;
    @(posedge sys_clk) disable iff (sys_rst)
      (st_ff == ST_PAUSED) ##[1:50] mod_active_ff;
  endproperty
  c_pause_resume: cover property (p_cov_pause_resume);

  property p_cov_blocked_clear;
    @(posedge sys_clk) disable iff (sys_rst) conflict_ff ##1 !conflict_ff && mod_active_ff;
  endproperty
  c_blocked_clear: cover property (p_cov_blocked_clear);

  property p_cov_fsk_hop;
    @(posedge sys_clk) disable iff (sys_rst)
      mod_active_ff && kind == mcsub_pkg::MCS_FSK && out_freq_ff == alt_ff;
  endproperty
  c_fsk_hop: cover property (p_cov_fsk_hop);
endmodule : mcsub_ctrl

// ### design/mcsub_pkg.sv
package mcsub_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SHAPE = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_PHASE = 8'h0c;
  localparam logic [7:0] OFS_WIDTH = 8'h10;
  localparam logic [7:0] OFS_CARRIER = 8'h14;
  localparam logic [7:0] OFS_ALT = 8'h18;
  localparam logic [7:0] OFS_AUX = 8'h1c;
  localparam logic [7:0] OFS_AUX_RATE = 8'h20;
  localparam logic [7:0] OFS_CMD = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_TBL_PTR = 8'h2c;
  localparam logic [7:0] OFS_TBL_DATA = 8'h30;
  // Control field positions
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_POL_BIT = 6;
  localparam int CTRL_ADD_BIT = 7;
  localparam int CTRL_SWEEP_BIT = 8;
  localparam int CTRL_FSWEEP_BIT = 9;
  localparam int CTRL_CARR_LSB = 10;
  localparam int CMD_PAUSE_BIT = 0;
  localparam int CMD_RESUME_BIT = 1;
  localparam int AUX_SEL_LSB = 0;
  localparam int AUX_WAVE_LSB = 2;
  localparam int AUX_OFS_LSB = 16;
  localparam int SHAPE_AUX_LSB = 4;
  // Reset values and output codes
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RATE_RST = 32'h0001_0000;
  localparam logic [15:0] WIDTH_RST = 16'h0000;
  localparam logic [15:0] AUX_ZERO = 16'h0000;
  localparam logic [15:0] AUX_HI = 16'h7fff;
  localparam logic [15:0] AUX_LO = 16'h8001;
  localparam int TBL_DEPTH = 4096;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef enum logic [3:0] {MCS_OFF, MCS_FM, MCS_FSK, MCS_PM, MCS_PSK, MCS_AM,
    MCS_AMSC, MCS_OFFSET, MCS_PWM} mcs_kind_t;
  typedef enum logic [2:0] {SH_SINE, SH_SQUARE, SH_TRIANGLE, SH_RISE, SH_FALL,
    SH_NOISE, SH_TABLE, SH_SHAPED} mcs_shape_t;
  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_EXT_ONE, SRC_EXT_TWO} mcs_src_t;
  typedef enum logic [1:0] {AUX_SYNC, AUX_MOD_SYNC, AUX_WAVE, AUX_OFFSEL} mcs_aux_t;
  typedef enum logic [1:0] {CAR_NORMAL, CAR_NOISE, CAR_PULSE, CAR_DC} mcs_car_t;

  // Plain register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mcs_bus_t;
endpackage : mcsub_pkg

// ### verification/mcsub_ext_src.sv
`timescale 1ns/1ps
// Far-side stand-in: keying pin, analogue modulator and main phase reference
module mcsub_ext_src (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic key_level,
  input wire logic signed [15:0] level_in,
  output logic ext_trigger,
  output logic signed [15:0] ext_analog,
  output logic main_phase_msb,
  output logic phase_ref_zero
);
  logic [3:0] phase_cnt_ff;
  // Main phase stand-in, reference pulse at each wrap
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      phase_cnt_ff <= 4'h0;
    else
      phase_cnt_ff <= phase_cnt_ff + 4'h1;
  end
  assign main_phase_msb = phase_cnt_ff[3];
  assign phase_ref_zero = (phase_cnt_ff == 4'h0);
  // Logic-level keying and analogue sample, changed just after the edge
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_trigger <= 1'b0;
      ext_analog <= 16'sh0000;
    end
    else
    begin
      ext_trigger <= key_level;
      ext_analog <= level_in;
    end
  end
endmodule : mcsub_ext_src

// ### verification/modulation_control_sub_output_tb_top.sv
`timescale 1ns/1ps
module modulation_control_sub_output_tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  mcsub_pkg::mcs_bus_t bus = '0;
  logic key_level = 1'b0;
  logic signed [15:0] level_in = 16'sh0000;
  logic ext_trigger, main_phase_msb, phase_ref_zero, mod_active_ff, conflict_ff;
  logic signed [15:0] ext_analog, out_mod_ff, aux_code_ff;
  logic [31:0] rdata_ff, out_freq_ff;
  int error_cnt = 0;
  int compares = 0;
  localparam logic [31:0] CARR = 32'h0012_3400;
  localparam logic [31:0] ALT = 32'h0055_0000;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  mcsub_ext_src SRC (.sys_clk(sys_clk), .sys_rst(sys_rst), .key_level(key_level),
    .level_in(level_in), .ext_trigger(ext_trigger), .ext_analog(ext_analog),
    .main_phase_msb(main_phase_msb), .phase_ref_zero(phase_ref_zero));
  mcsub_ctrl DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .ext_trigger(ext_trigger),
    .ext_analog(ext_analog), .main_phase_msb(main_phase_msb), .phase_ref_zero(phase_ref_zero),
    .rdata_ff(rdata_ff), .out_freq_ff(out_freq_ff), .out_mod_ff(out_mod_ff),
    .mod_active_ff(mod_active_ff), .conflict_ff(conflict_ff), .aux_code_ff(aux_code_ff));
  task automatic test_done;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 chk(rdata_ff, exp);
  endtask : rd_chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // Control word: kind, source, {fsweep, sweep, add, pol}, carrier class
  function automatic logic [31:0] ctl(input logic [3:0] k, input logic [1:0] s,
    input logic [3:0] f, input logic [1:0] c);
    return {20'h0, c, f, s, k};
  endfunction : ctl
  task automatic t_reset;
    chk(aux_code_ff[15:0], mcsub_pkg::AUX_ZERO);
    chk(mod_active_ff, 1'b0);
    rd_chk(mcsub_pkg::OFS_CTRL, mcsub_pkg::CTRL_RST);
    rd_chk(mcsub_pkg::OFS_STATUS, 32'h0);
    wr(8'hfc, 32'hffff_ffff);
    rd_chk(8'hfc, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_kinds;
    wr(mcsub_pkg::OFS_CARRIER, CARR);
    for (int k = 1; k <= 9; k++)
    begin
      wr(mcsub_pkg::OFS_CTRL, ctl(k[3:0], 2'h0, 4'h0, 2'h0));
      cyc(2);
      chk(mod_active_ff, (k <= 8));
      chk(conflict_ff, (k > 8));
    end
    wr(mcsub_pkg::OFS_CTRL, 32'h0);
    cyc(2);
    chk(mod_active_ff, 1'b0);
    $display("t_kinds done");
  endtask : t_kinds
  task automatic t_conflict;
    for (int c = 1; c <= 3; c++)
    begin
      wr(mcsub_pkg::OFS_CTRL, ctl(4'h1, 2'h0, 4'h0, c[1:0]));
      cyc(2);
      chk(conflict_ff, 1'b1);
      chk(mod_active_ff, 1'b0);
    end
    rd_chk(mcsub_pkg::OFS_STATUS, 32'ha);
    wr(mcsub_pkg::OFS_CTRL, ctl(4'h1, 2'h0, 4'h8, 2'h0));
    cyc(2);
    chk(conflict_ff, 1'b1);
    wr(mcsub_pkg::OFS_CTRL, ctl(4'h5, 2'h0, 4'h4, 2'h0));
    cyc(2);
    chk(conflict_ff, 1'b1);
    wr(mcsub_pkg::OFS_CTRL, ctl(4'h5, 2'h1, 4'h2, 2'h0));
    cyc(2);
    chk(conflict_ff, 1'b1);
    wr(mcsub_pkg::OFS_CTRL, ctl(4'h5, 2'h1, 4'h4, 2'h0));
    cyc(2);
    chk(mod_active_ff, 1'b1);
    $display("t_conflict done");
  endtask : t_conflict
  task automatic t_pause;
    wr(mcsub_pkg::OFS_WIDTH, 32'h0000_4000);
    wr(mcsub_pkg::OFS_CTRL, ctl(4'h1, 2'h0, 4'h0, 2'h0));
    wr(mcsub_pkg::OFS_CMD, 32'h1);
    cyc(2);
    chk(mod_active_ff, 1'b0);
    chk(out_freq_ff, CARR);
    chk(out_mod_ff[15:0], 16'h0000);
    rd_chk(mcsub_pkg::OFS_STATUS, 32'hc);
    wr(mcsub_pkg::OFS_CMD, 32'h2);
    cyc(2);
    chk(mod_active_ff, 1'b1);
    wr(mcsub_pkg::OFS_CTRL, ctl(4'h1, 2'h1, 4'h0, 2'h0));
    level_in <= 16'sh7fff;
    cyc(4);
    chk(out_freq_ff, CARR + 32'h0000_3fff);
    chk(out_mod_ff[15:0], 16'h3fff);
    wr(mcsub_pkg::OFS_WIDTH, 32'h0);
    repeat (8)
    begin
      cyc(1);
      chk(out_freq_ff, CARR);
    end
    $display("t_pause done");
  endtask : t_pause
  task automatic t_keying;
    wr(mcsub_pkg::OFS_ALT, ALT);
    for (int i = 0; i < 4; i++)
    begin
      wr(mcsub_pkg::OFS_CTRL, ctl(4'h2, 2'(i % 3 + 1), {3'h0, i[1]}, 2'h0));
      @(posedge sys_clk);
      key_level <= i[0];
      cyc(8);
      chk(out_freq_ff, (i[0] ^ i[1]) ? ALT : CARR);
    end
    $display("t_keying done");
  endtask : t_keying
  task automatic t_aux;
    logic prev;
    wr(mcsub_pkg::OFS_AUX, 32'h3);
    cyc(2);
    chk(aux_code_ff[15:0], mcsub_pkg::AUX_ZERO);
    wr(mcsub_pkg::OFS_CTRL, ctl(4'h2, 2'h0, 4'h0, 2'h0));
    wr(mcsub_pkg::OFS_AUX, 32'h2);
    cyc(2);
    chk(aux_code_ff[15:0], mcsub_pkg::AUX_ZERO);
    wr(mcsub_pkg::OFS_CTRL, ctl(4'h1, 2'h0, 4'h0, 2'h0));
    wr(mcsub_pkg::OFS_SHAPE, 32'h5);
    wr(mcsub_pkg::OFS_AUX, 32'h1);
    repeat (8)
    begin
      cyc(1);
      chk(aux_code_ff[15:0], mcsub_pkg::AUX_LO);
    end
    wr(mcsub_pkg::OFS_AUX, 32'h0);
    cyc(1);
    repeat (16)
    begin
      prev = main_phase_msb;
      cyc(1);
      chk(aux_code_ff[15:0], prev ? mcsub_pkg::AUX_LO : mcsub_pkg::AUX_HI);
    end
    wr(mcsub_pkg::OFS_RATE, 32'h0);
    wr(mcsub_pkg::OFS_SHAPE, 32'h6);
    wr(mcsub_pkg::OFS_TBL_PTR, 32'h0);
    wr(mcsub_pkg::OFS_TBL_DATA, 32'h0000_4000);
    rd_chk(mcsub_pkg::OFS_TBL_PTR, 32'h1);
    wr(mcsub_pkg::OFS_AUX, 32'h0000_7ffe);
    cyc(20);
    chk(aux_code_ff[15:0], 16'h3fff);
    $display("t_aux done");
  endtask : t_aux
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cyc(1);
    t_reset();
    t_kinds();
    t_conflict();
    t_pause();
    t_keying();
    t_aux();
    test_done();
  end
endmodule : modulation_control_sub_output_tb_top
